// *** rtl/cts_pkg.sv ***
// Package with register map, field positions and carrier types of the transmit status block.
package cts_pkg;

	localparam int NUM_TX = 2;
	localparam int NUM_RX = 4;

	localparam logic [7:0] ADDR_PORT_SEL   = 8'h32;
	localparam logic [7:0] ADDR_TX_CTRL2   = 8'h34;
	localparam logic [7:0] ADDR_TX_STATUS  = 8'h35;
	localparam logic [7:0] ADDR_INT_ENABLE = 8'h36;
	localparam logic [7:0] ADDR_INT_STATUS = 8'h37;
	localparam logic [7:0] ADDR_RESERVED   = 8'h38;

	localparam int SEL_WR_PORT0 = 0;
	localparam int SEL_WR_PORT1 = 1;
	localparam int SEL_RD_PORT  = 4;
	localparam logic [7:0] SEL_WMASK = 8'h13;
	localparam logic [7:0] SEL_RESET = 8'h00;

	localparam int CTRL2_PASS_MODE = 3;
	localparam logic [7:0] CTRL2_WMASK = 8'h08;

	localparam int STS_PORT_NUM = 4;
	localparam int STS_SYNCED   = 1;
	localparam int STS_PASS     = 0;

	localparam int EV_FORWARDED_RX = 4;
	localparam int EV_ALIGN_ERROR  = 3;
	localparam int EV_ALIGNED      = 2;
	localparam int EV_VALID_LOSS   = 1;
	localparam int EV_VALID        = 0;
	localparam int NUM_EV          = 5;
	localparam logic [4:0] EV_RESET = 5'h00;
	localparam logic [4:0] EN_RESET = 5'h00;

	typedef enum logic [0:0] {
		CTS_PASS_ANY = 1'b0,
		CTS_PASS_ALL = 1'b1
	} cts_pass_mode_t;

	// Per transmit port conditions from the forwarding path.
	typedef struct packed {
		logic             sync_enable;
		logic             aligned;
		logic             align_error;
		logic             tx_error;
		logic [NUM_RX-1:0] fwd_map;
	} cts_fwd_t;

	// Per transmit port state seen by the register file.
	typedef struct packed {
		logic              pass;
		logic              aligned;
		logic [NUM_EV-1:0] flags;
		logic [NUM_EV-1:0] enables;
	} cts_port_stat_t;

endpackage

// *** rtl/cts_tx_port.sv ***
// One transmit port copy: live status, sticky event flags and their enables.
module cts_tx_port (
	// Clock and reset
	input  wire logic                        i_clk,
	input  wire logic                        i_rst,
	// Forwarding path
	input  wire cts_pkg::cts_fwd_t           i_fwd,
	input  wire logic [cts_pkg::NUM_RX-1:0]  i_rx_valid,
	input  wire logic [cts_pkg::NUM_RX-1:0]  i_rx_event,
	input  wire logic [cts_pkg::NUM_RX-1:0]  i_rx_status_read,
	input  wire logic                        i_pass_mode,
	// Register access
	input  wire logic                        i_en_wr,
	input  wire logic [cts_pkg::NUM_EV-1:0]  i_en_wdata,
	input  wire logic                        i_flags_rd,
	// Status
	output cts_pkg::cts_port_stat_t          o_stat
);
	localparam int NR = cts_pkg::NUM_RX;
	localparam int NE = cts_pkg::NUM_EV;

	logic [NR-1:0] rx_fwd_valid;
	logic          valid_any;
	logic          valid_all;
	logic          pass_d;
	logic          pass_q;
	logic          aligned_d;
	logic          aligned_q;
	logic [NR-1:0] rx_valid_q;
	logic [NR-1:0] rx_pend_q;
	logic [NR-1:0] rx_pend_d;
	logic [NE-1:0] ev_set;
	logic [NE-1:0] flags_q;
	logic [NE-1:0] flags_d;
	logic [NE-1:0] en_q;

	assign rx_fwd_valid = i_rx_valid & i_fwd.fwd_map;
	assign valid_any    = |rx_fwd_valid;
	assign valid_all    = (i_fwd.fwd_map != '0) && (rx_fwd_valid == i_fwd.fwd_map);
	// Without alignment a transmission error drops pass; aligned forwarding only reports data ready.
	assign pass_d    = ((i_pass_mode == cts_pkg::CTS_PASS_ALL) ? valid_all : valid_any) // R4 R16
		&& (i_fwd.sync_enable || !i_fwd.tx_error); // R5 R6
	assign aligned_d = i_fwd.sync_enable && i_fwd.aligned; // R2 R3

	// A receiver event stays pending until that receiver's own status is read.
	assign rx_pend_d = (rx_pend_q & ~i_rx_status_read) | (i_rx_event & i_fwd.fwd_map); // R8

	assign ev_set[cts_pkg::EV_FORWARDED_RX] = |rx_pend_d; // R7
	assign ev_set[cts_pkg::EV_ALIGN_ERROR]  = i_fwd.sync_enable && i_fwd.align_error; // R9
	assign ev_set[cts_pkg::EV_ALIGNED]      = aligned_d && !aligned_q; // R10
	assign ev_set[cts_pkg::EV_VALID_LOSS]   = |(rx_valid_q & ~i_rx_valid & i_fwd.fwd_map); // R11
	assign ev_set[cts_pkg::EV_VALID]        = pass_d && !pass_q; // R12

	// Set wins over the read clear; the forwarded flag follows its pending sources only.
	assign flags_d = {|rx_pend_d,
		(flags_q[NE-2:0] & {(NE-1){!i_flags_rd}}) | ev_set[NE-2:0]};

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			pass_q     <= 1'b0;
			aligned_q  <= 1'b0;
			rx_valid_q <= '0;
			rx_pend_q  <= '0;
			flags_q    <= cts_pkg::EV_RESET;
			en_q       <= cts_pkg::EN_RESET; // R13
		end else begin
			pass_q     <= pass_d;
			aligned_q  <= aligned_d;
			rx_valid_q <= i_rx_valid;
			rx_pend_q  <= rx_pend_d;
			flags_q    <= flags_d; // R9 R10 R11 R12
			if (i_en_wr) begin
				en_q <= i_en_wdata; // R13
			end
		end
	end

	assign o_stat.pass    = pass_q;
	assign o_stat.aligned = aligned_q;
	assign o_stat.flags   = flags_q;
	assign o_stat.enables = en_q;

endmodule

// *** rtl/cts_csi_tx_status.sv ***
// Transmit port status and interrupt registers for both transmit ports.
//
// Behaviour
// R1: Status bit 4 returns selected read port.
// R2: Status bit 1 shows streams aligned.
// R3: Aligned bit reads 0 when alignment off.
// R4: Status bit 0 shows valid data, any/all.
// R5: Unaligned forwarding: pass drops on transmit error.
// R6: Aligned forwarding: pass means data ready.
// R7: Flag bit 4 sets on forwarded receiver event.
// R8: Receiver status read clears it, not this.
// R9: Flag bit 3 latches alignment error, read-clear.
// R10: Flag bit 2 latches aligned rising edge.
// R11: Flag bit 1 latches forwarded valid loss.
// R12: Flag bit 0 latches pass rising edge.
// R13: Enable bits 4..0 read/write, reset zero.
// R14: Valid-loss and aligned events gated by enables.
// R15: Status registers exist per transmit port.
// R16: Pass mode bit picks any or all.
// R17: Select bit 4 reads, bits 1:0 write.
// R18: Interrupt output ORs enabled latched flags.
// R19: Reserved bits and register read zero.
module cts_csi_tx_status #(
	parameter int NUM_TX = cts_pkg::NUM_TX,
	parameter int NUM_RX = cts_pkg::NUM_RX
) (
	// Clock and reset
	input  wire logic                    i_clk,
	input  wire logic                    i_rst,
	// Register port from the serial control bus
	input  wire logic                    i_reg_wr,
	input  wire logic                    i_reg_rd,
	input  wire logic [7:0]              i_reg_addr,
	input  wire logic [7:0]              i_reg_wdata,
	output logic [7:0]                   o_reg_rdata,
	output logic                         o_reg_rvalid,
	// Forwarding path, one entry per transmit port
	input  wire cts_pkg::cts_fwd_t       i_fwd [NUM_TX],
	// Receive ports
	input  wire logic [NUM_RX-1:0]       i_rx_valid,
	input  wire logic [NUM_RX-1:0]       i_rx_event,
	input  wire logic [NUM_RX-1:0]       i_rx_status_read,
	// Interrupt and live status
	output logic                         o_int,
	output logic [NUM_TX-1:0]            o_tx_pass,
	output logic [NUM_TX-1:0]            o_tx_aligned
);
	// One select bit picks the read copy, and the carrier fixes the receive port count.
	generate
		if (NUM_TX != 2) begin : g_bad_tx
			$error("NUM_TX must be 2");
		end
		if (NUM_RX != cts_pkg::NUM_RX) begin : g_bad_rx
			$error("NUM_RX must match the carrier width");
		end
	endgenerate

	// Port select register.
	logic [7:0] sel_q;
	logic       rd_port;
	logic [1:0] wr_ports;

	// Per port pass mode register.
	logic [NUM_TX-1:0] pass_mode_q;

	// Address decode.
	logic hit_sel;
	logic hit_ctrl2;
	logic hit_status;
	logic hit_enable;
	logic hit_flags;
	logic hit_reserved;

	// Per port strobes and state.
	logic [NUM_TX-1:0]       port_rd_sel;
	logic [NUM_TX-1:0]       en_wr;
	logic [NUM_TX-1:0]       ctrl2_wr;
	logic [NUM_TX-1:0]       flags_rd;
	cts_pkg::cts_port_stat_t stat [NUM_TX];
	logic [NUM_TX-1:0]       port_int;

	// Read path.
	cts_pkg::cts_port_stat_t rd_stat;
	logic                    rd_pass_mode;
	logic [7:0]              rd_status_val;
	logic [7:0]              rd_enable_val;
	logic [7:0]              rd_flags_val;
	logic [7:0]              rd_sel_val;
	logic [7:0]              rd_ctrl2_val;
	logic [7:0]              rdata_d;
	logic [7:0]              rdata_q;
	logic                    rvalid_q;
	logic                    int_q;

	assign rd_port  = sel_q[cts_pkg::SEL_RD_PORT]; // R17
	assign wr_ports = {sel_q[cts_pkg::SEL_WR_PORT1], sel_q[cts_pkg::SEL_WR_PORT0]}; // R17

	assign hit_sel      = (i_reg_addr == cts_pkg::ADDR_PORT_SEL);
	assign hit_ctrl2    = (i_reg_addr == cts_pkg::ADDR_TX_CTRL2);
	assign hit_status   = (i_reg_addr == cts_pkg::ADDR_TX_STATUS);
	assign hit_enable   = (i_reg_addr == cts_pkg::ADDR_INT_ENABLE);
	assign hit_flags    = (i_reg_addr == cts_pkg::ADDR_INT_STATUS);
	assign hit_reserved = (i_reg_addr == cts_pkg::ADDR_RESERVED);

	// Writes reach every copy whose write enable is set; reads reach one copy.
	genvar gp;
	generate
		for (gp = 0; gp < NUM_TX; gp++) begin : g_port
			assign port_rd_sel[gp] = (rd_port == 1'(gp)); // R15
			assign en_wr[gp]       = i_reg_wr && hit_enable && wr_ports[gp]; // R15 R17
			assign ctrl2_wr[gp]    = i_reg_wr && hit_ctrl2 && wr_ports[gp]; // R15 R17
			assign flags_rd[gp]    = i_reg_rd && hit_flags && port_rd_sel[gp]; // R15

			cts_tx_port u_port (
				.i_clk            (i_clk),
				.i_rst            (i_rst),
				.i_fwd            (i_fwd[gp]),
				.i_rx_valid       (i_rx_valid),
				.i_rx_event       (i_rx_event),
				.i_rx_status_read (i_rx_status_read),
				.i_pass_mode      (pass_mode_q[gp]),
				.i_en_wr          (en_wr[gp]),
				.i_en_wdata       (i_reg_wdata[cts_pkg::NUM_EV-1:0]),
				.i_flags_rd       (flags_rd[gp]),
				.o_stat           (stat[gp])
			);

			// Every event bit, including bits 1 and 2, reaches the pin only through its enable.
			assign port_int[gp] = |(stat[gp].flags & stat[gp].enables); // R14 R18

			assign o_tx_pass[gp]    = stat[gp].pass;
			assign o_tx_aligned[gp] = stat[gp].aligned;

			always_ff @(posedge i_clk or posedge i_rst) begin
				if (i_rst) begin
					pass_mode_q[gp] <= 1'b0;
				end else if (ctrl2_wr[gp]) begin
					pass_mode_q[gp] <= i_reg_wdata[cts_pkg::CTRL2_PASS_MODE]; // R16
				end
			end
		end
	endgenerate

	assign rd_stat      = stat[rd_port];
	assign rd_pass_mode = pass_mode_q[rd_port];

	assign rd_status_val = {3'h0, rd_port, 2'h0, rd_stat.aligned, rd_stat.pass}; // R1 R2 R4 R19
	assign rd_enable_val = {3'h0, rd_stat.enables}; // R13 R19
	assign rd_flags_val  = {3'h0, rd_stat.flags}; // R19
	assign rd_sel_val    = sel_q & cts_pkg::SEL_WMASK;
	assign rd_ctrl2_val  = {4'h0, rd_pass_mode, 3'h0};

	// Unmapped and reserved addresses answer zero.
	assign rdata_d = hit_sel    ? rd_sel_val    :
		hit_ctrl2  ? rd_ctrl2_val  :
		hit_status ? rd_status_val :
		hit_enable ? rd_enable_val :
		hit_flags  ? rd_flags_val  :
		8'h00; // R19

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			sel_q <= cts_pkg::SEL_RESET;
		end else if (i_reg_wr && hit_sel) begin
			sel_q <= i_reg_wdata & cts_pkg::SEL_WMASK; // R17
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			rdata_q  <= 8'h00;
			rvalid_q <= 1'b0;
		end else begin
			rvalid_q <= i_reg_rd;
			if (i_reg_rd) begin
				rdata_q <= rdata_d;
			end
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			int_q <= 1'b0;
		end else begin
			int_q <= |port_int; // R18
		end
	end

	assign o_reg_rdata  = rdata_q;
	assign o_reg_rvalid = rvalid_q;
	assign o_int        = int_q;

endmodule

// *** verification/cts_checker.sv ***
// Checker on the ports of the transmit status block.
module cts_checker #(
	parameter int NUM_TX = 2,
	parameter int NUM_RX = 4
) (
	// Clock, reset and register port
	input wire logic              i_clk,
	input wire logic              i_rst,
	input wire logic              i_reg_wr,
	input wire logic              i_reg_rd,
	input wire logic [7:0]        i_reg_addr,
	input wire logic [7:0]        i_reg_wdata,
	input wire logic [7:0]        o_reg_rdata,
	input wire logic              o_reg_rvalid,
	// Forwarding path and receive ports
	input wire cts_pkg::cts_fwd_t i_fwd [NUM_TX],
	input wire logic [NUM_RX-1:0] i_rx_valid,
	input wire logic [NUM_RX-1:0] i_rx_event,
	input wire logic [NUM_RX-1:0] i_rx_status_read,
	// Interrupt and live status
	input wire logic              o_int,
	input wire logic [NUM_TX-1:0] o_tx_pass,
	input wire logic [NUM_TX-1:0] o_tx_aligned
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	sequence rd_at(a);
		i_reg_rd && i_reg_addr == a;
	endsequence
	rd_answer_a: assert property (i_reg_rd |=> o_reg_rvalid)
		else $error("read not answered");
	rvalid_cause_a: assert property (o_reg_rvalid |-> $past(i_reg_rd))
		else $error("answer without read");
	aligned_zero_a: assert property (1 |=> o_tx_aligned[0] == $past(i_fwd[0].sync_enable & i_fwd[0].aligned))
		else $error("port 0 aligned wrong");
	aligned_one_a: assert property (1 |=> o_tx_aligned[1] == $past(i_fwd[1].sync_enable & i_fwd[1].aligned))
		else $error("port 1 aligned wrong");
	pass_cause_a: assert property (o_tx_pass[0] |->
		$past(|(i_rx_valid & i_fwd[0].fwd_map) && (i_fwd[0].sync_enable || !i_fwd[0].tx_error)))
		else $error("pass without cause");
	rsvd_reg_a: assert property (rd_at(8'h38) |=> o_reg_rdata == 8'h00)
		else $error("reserved register not zero");
	sts_rsvd_a: assert property (rd_at(8'h35) |=> o_reg_rdata[7:5] == 3'h0 && o_reg_rdata[3:2] == 2'h0)
		else $error("status reserved bits set");
	en_rsvd_a: assert property (rd_at(8'h36) |=> o_reg_rdata[7:5] == 3'h0)
		else $error("enable reserved bits set");
endmodule

bind cts_csi_tx_status cts_checker #(.NUM_TX(NUM_TX), .NUM_RX(NUM_RX)) chk_u (
	.i_clk, .i_rst, .i_reg_wr, .i_reg_rd, .i_reg_addr, .i_reg_wdata, .o_reg_rdata,
	.o_reg_rvalid, .i_fwd, .i_rx_valid, .i_rx_event, .i_rx_status_read, .o_int,
	.o_tx_pass, .o_tx_aligned);

// *** verification/cts_host_model.sv ***
// Host model that reaches the registers and reads receive port status.
module cts_host_model (
	// Clock and answer
	input wire logic                   i_clk,
	input wire logic [7:0]             i_rdata,
	input wire logic                   i_rvalid,
	// Requests
	output logic                       o_wr,
	output logic                       o_rd,
	output logic [7:0]                 o_addr,
	output logic [7:0]                 o_wdata,
	output logic [cts_pkg::NUM_RX-1:0] o_rx_read
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		o_wr = 1'b0;
		o_rd = 1'b0;
		o_addr = 8'h00;
		o_wdata = 8'h00;
		o_rx_read = '0;
	end
	// A request stands for one edge; afterwards the bus shows inverted values.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clk);
		o_wr <= 1'b1;
		o_addr <= a;
		o_wdata <= d;
		@(posedge i_clk);
		o_wr <= 1'b0;
		o_addr <= ~a;
		o_wdata <= ~d;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
		@(posedge i_clk);
		o_rd <= 1'b1;
		o_addr <= a;
		@(posedge i_clk);
		o_rd <= 1'b0;
		o_addr <= ~a;
		#1;
		d = i_rdata;
		v = i_rvalid;
	endtask
	task automatic rx_read(input logic [3:0] m);
		@(posedge i_clk);
		o_rx_read <= m;
		@(posedge i_clk);
		o_rx_read <= '0;
	endtask
endmodule

// *** verification/cts_csi_tx_status_bench.sv ***
// Self-checking bench of the transmit status block.
module cts_csi_tx_status_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic              i_clk, i_rst, reg_wr, reg_rd, reg_rvalid, irq, v;
	logic [7:0]        reg_addr, reg_wdata, reg_rdata, got;
	logic [1:0]        tx_pass, tx_aligned;
	logic [3:0]        rx_valid, rx_event, rx_read;
	cts_pkg::cts_fwd_t fwd [2];
	int                fail_count = 0;
	int                num_checks = 0;
	int                cycles = 0;
	initial begin
		i_clk = 1'b0;
		forever #20 i_clk = ~i_clk;
	end
	cts_csi_tx_status dut_u (
		.i_clk(i_clk), .i_rst(i_rst), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd), .i_reg_addr(reg_addr),
		.i_reg_wdata(reg_wdata), .o_reg_rdata(reg_rdata), .o_reg_rvalid(reg_rvalid), .i_fwd(fwd),
		.i_rx_valid(rx_valid), .i_rx_event(rx_event), .i_rx_status_read(rx_read), .o_int(irq),
		.o_tx_pass(tx_pass), .o_tx_aligned(tx_aligned));
	cts_host_model host_u (
		.i_clk(i_clk), .i_rdata(reg_rdata), .i_rvalid(reg_rvalid), .o_wr(reg_wr), .o_rd(reg_rd),
		.o_addr(reg_addr), .o_wdata(reg_wdata), .o_rx_read(rx_read));
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input logic [8:0] g, input logic [8:0] e);
		num_checks++;
		if (g !== e) begin
			fail_count++;
			$display("BAD %0t got %h want %h", $time, g, e);
		end
	endtask
	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		host_u.rd(a, got, v);
		chk({v, got}, {1'b1, e});
	endtask
	task automatic settle;
		repeat (3) @(posedge i_clk);
	endtask
	task automatic t_regs;
		for (int a = 8'h35; a < 8'h39; a++) rchk(8'(a), 8'h00);
		host_u.wr(8'h32, 8'h03);
		host_u.wr(8'h36, 8'hFF);
		host_u.wr(8'h32, 8'h01);
		host_u.wr(8'h36, 8'h05);
		host_u.wr(8'h38, 8'hFF);
		host_u.wr(8'h35, 8'hFF);
		host_u.wr(8'h32, 8'h10);
		rchk(8'h36, 8'h1F);
		rchk(8'h35, 8'h10);
		rchk(8'h32, 8'h10);
		host_u.wr(8'h32, 8'h01);
		rchk(8'h36, 8'h05);
		rchk(8'h38, 8'h00);
	endtask
	task automatic t_pass;
		@(posedge i_clk);
		fwd[0].fwd_map <= 4'h1;
		rx_valid <= 4'h1;
		settle();
		chk({8'h00, irq}, 9'h001);
		rchk(8'h35, 8'h01);
		rchk(8'h37, 8'h01);
		rchk(8'h37, 8'h00);
		settle();
		chk({8'h00, irq}, 9'h000);
		host_u.wr(8'h34, 8'h08);
		@(posedge i_clk);
		fwd[0].fwd_map <= 4'h3;
		settle();
		rchk(8'h35, 8'h00);
		@(posedge i_clk);
		rx_valid <= 4'h3;
		settle();
		rchk(8'h37, 8'h01);
		@(posedge i_clk);
		rx_valid <= 4'h1;
		settle();
		chk({8'h00, irq}, 9'h000);
		rchk(8'h37, 8'h02);
		rchk(8'h34, 8'h08);
	endtask
	task automatic t_sync;
		@(posedge i_clk);
		rx_valid <= 4'h3;
		fwd[0].tx_error <= 1'b1;
		settle();
		rchk(8'h35, 8'h00);
		@(posedge i_clk);
		fwd[0].sync_enable <= 1'b1;
		fwd[0].aligned <= 1'b1;
		settle();
		chk({8'h00, irq}, 9'h001);
		rchk(8'h35, 8'h03);
		rchk(8'h37, 8'h05);
		@(posedge i_clk);
		fwd[0].align_error <= 1'b1;
		@(posedge i_clk);
		fwd[0].align_error <= 1'b0;
		settle();
		rchk(8'h37, 8'h08);
		@(posedge i_clk);
		fwd[0].sync_enable <= 1'b0;
		settle();
		rchk(8'h35, 8'h00);
	endtask
	task automatic t_rx;
		@(posedge i_clk);
		rx_event <= 4'h6;
		@(posedge i_clk);
		rx_event <= 4'h0;
		settle();
		rchk(8'h37, 8'h10);
		rchk(8'h37, 8'h10);
		host_u.rx_read(4'h2);
		settle();
		rchk(8'h37, 8'h00);
	endtask
	always @(posedge i_clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			fail_count++;
			report_and_stop();
		end
	end
	initial begin
		i_rst = 1'b1;
		fwd[0] = '0;
		fwd[1] = '0;
		rx_valid = 4'h0;
		rx_event = 4'h0;
		repeat (4) @(posedge i_clk);
		i_rst <= 1'b0;
		t_regs();
		t_pass();
		t_sync();
		t_rx();
		report_and_stop();
	end
endmodule
